// *** src/addr_resolve_if.sv ***
// operand address request and answer between decoder and resolver
`timescale 1ns/10ps
interface addr_resolve_if;
  logic [7:0]  file_field;
  logic        access_sel;
  logic [3:0]  bank;
  logic        extended_enable;
  logic [11:0] index_base;
  logic [11:0] address;
  logic        indexed;
  modport decoder  (output file_field, access_sel, bank, extended_enable,
                    index_base, input address, indexed);
  modport resolver (input file_field, access_sel, bank, extended_enable,
                    index_base, output address, indexed);
endinterface

// *** src/decrement_skip_execution.sv ***
// execution of the decrement-and-skip instructions
// Behaviour
// - decrement file; destination selects working or file
// - skip-if-zero discards next instruction on zero
// - skip of a one-word instruction spends one no-operation cycle
// - skipped two-word instruction costs two no-operations
// - skip-if-nonzero discards next instruction on nonzero
// - access selector picks access bank or bank
// - indexed literal offset when access bank selected, extended and small
`timescale 1ns/10ps
module decrement_skip_execution (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // instruction in
  input  wire logic [15:0] instr,
  input  wire logic        instr_valid,
  input  wire logic        next_two_word,
  // addressing context
  input  wire logic [3:0]  bank_select_register,
  input  wire logic        extended_enable,
  input  wire logic [11:0] index_base,
  // data memory
  output logic      [11:0] file_addr,
  input  wire logic [7:0]  file_rdata,
  output logic      [7:0]  file_wdata,
  output logic             file_we,
  // working register
  output logic      [7:0]  work_wdata,
  output logic             work_we,
  // pipeline control
  output logic             busy,
  output logic             discard_next,
  output logic             nop_cycle,
  output logic             indexed_mode
);
  // ************************************************************
  // decode
  // ************************************************************
  typedef enum logic [1:0] {st_idle, st_read, st_write, st_nop} state_type;

  state_type   state;
  state_type   next_state;
  logic        op_is_zero_skip;
  logic        dest_sel;
  logic [1:0]  nops_left;

  wire [5:0] opcode = instr[decrement_skip_pkg::opcode_msb:
                            decrement_skip_pkg::opcode_lsb];
  wire       is_zero_op    =
    (opcode == decrement_skip_pkg::op_skip_zero);
  wire       is_nonzero_op =
    (opcode == decrement_skip_pkg::op_skip_nonzero);
  wire       known_op      = is_zero_op || is_nonzero_op;
  wire       in_idle       = (state == st_idle);
  wire       in_read       = (state == st_read);
  wire       in_nop        = (state == st_nop);
  wire       accept        = in_idle && instr_valid && known_op;
  wire       dest_field    = instr[decrement_skip_pkg::dest_bit];

  // ************************************************************
  // address resolution
  // ************************************************************
  addr_resolve_if resolve ();
  assign resolve.file_field      = instr[decrement_skip_pkg::file_msb:
                                         decrement_skip_pkg::file_lsb];
  assign resolve.access_sel      = instr[decrement_skip_pkg::access_bit];
  assign resolve.bank            = bank_select_register;
  assign resolve.extended_enable = extended_enable;
  assign resolve.index_base      = index_base;

  operand_address resolver (
    .port (resolve.resolver)
  );

  // ************************************************************
  // execute
  // ************************************************************
  wire [7:0] result      = file_rdata - decrement_skip_pkg::data_one;
  wire       result_zero = (result == decrement_skip_pkg::data_zero);
  wire       skip = op_is_zero_skip ? result_zero :
                                      !result_zero;
  wire to_working = (dest_sel == decrement_skip_pkg::dest_working);
  wire [1:0] nops_needed = next_two_word ?
                           decrement_skip_pkg::nops_two_word :
                           decrement_skip_pkg::nops_one_word;

  wire       nops_done   = (nops_left == 2'h1);
  wire       nops_owed   = (nops_left != 2'h0);

  always_comb begin
    next_state = state;
    case (state)
      st_idle:  next_state = accept ? st_read : st_idle;
      st_read:  next_state = st_write;
      st_write: next_state = nops_owed ? st_nop : st_idle;
      st_nop:   next_state = nops_done ? st_idle : st_nop;
      default:  next_state = st_idle;
    endcase
  end

  // ************************************************************
  // next values
  // ************************************************************
  wire        next_op_is_zero_skip =
    accept ? is_zero_op : op_is_zero_skip;
  wire        next_dest_sel =
    accept ? dest_field : dest_sel;
  wire [11:0] next_file_addr =
    accept ? resolve.address : file_addr;
  wire        next_indexed_mode =
    accept ? resolve.indexed : indexed_mode;
  wire        next_file_we =
    in_read && !to_working;
  wire        next_work_we =
    in_read && to_working;
  wire [7:0]  next_file_wdata =
    in_read ? result : file_wdata;
  wire [7:0]  next_work_wdata =
    in_read ? result : work_wdata;
  wire        next_discard_next =
    in_read && skip;
  wire        next_nop_cycle =
    (next_state == st_nop);
  wire        next_busy =
    (next_state != st_idle);
  wire [1:0]  next_nops_left =
    in_read ? (skip ? nops_needed : 2'h0) :
              (in_nop ? nops_left - 2'h1 : nops_left);

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= st_idle;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      op_is_zero_skip <= 1'b0;
    end else begin
      op_is_zero_skip <= next_op_is_zero_skip;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      dest_sel <= 1'b1;
    end else begin
      dest_sel <= next_dest_sel;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      file_addr <= decrement_skip_pkg::addr_reset;
    end else begin
      file_addr <= next_file_addr;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      indexed_mode <= 1'b0;
    end else begin
      indexed_mode <= next_indexed_mode;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      file_we <= 1'b0;
    end else begin
      file_we <= next_file_we;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      work_we <= 1'b0;
    end else begin
      work_we <= next_work_we;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      file_wdata <= 8'h00;
    end else begin
      file_wdata <= next_file_wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      work_wdata <= 8'h00;
    end else begin
      work_wdata <= next_work_wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      discard_next <= 1'b0;
    end else begin
      discard_next <= next_discard_next;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      nop_cycle <= 1'b0;
    end else begin
      nop_cycle <= next_nop_cycle;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      busy <= 1'b0;
    end else begin
      busy <= next_busy;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      nops_left <= 2'h0;
    end else begin
      nops_left <= next_nops_left;
    end
  end
endmodule

// *** src/decrement_skip_pkg.sv ***
// constants shared by the decrement-and-skip execution block
package decrement_skip_pkg;
  // instruction word layout
  localparam int          instr_width    = 16;
  localparam int          opcode_msb     = 15;
  localparam int          opcode_lsb     = 10;
  localparam int          dest_bit       = 9;
  localparam int          access_bit     = 8;
  localparam int          file_msb       = 7;
  localparam int          file_lsb       = 0;
  localparam logic [5:0]  op_skip_zero   = 6'h0b;
  localparam logic [5:0]  op_skip_nonzero = 6'h13;
  // destination and access selector codes
  localparam logic        dest_working   = 1'h0;
  localparam logic        access_bank    = 1'h0;
  // data space addressing
  localparam int          data_addr_width = 12;
  localparam int          bank_width      = 4;
  localparam logic [7:0]  indexed_limit   = 8'h5f;
  localparam logic [7:0]  access_split    = 8'h60;
  localparam logic [3:0]  access_low_bank = 4'h0;
  localparam logic [3:0]  access_high_bank = 4'hf;
  // nop cycles inserted on a skip, data constants and address reset value
  localparam logic [1:0]  nops_one_word  = 2'h1;
  localparam logic [1:0]  nops_two_word  = 2'h2;
  localparam logic [7:0]  data_one       = 8'h01;
  localparam logic [7:0]  data_zero      = 8'h00;
  localparam logic [11:0] addr_reset     = 12'h000;
endpackage

// *** src/operand_address.sv ***
// resolves the data space address of a file operand
`timescale 1ns/10ps
module operand_address (
  addr_resolve_if.resolver port
);
  wire in_access = (port.access_sel == decrement_skip_pkg::access_bank);
  wire low_part  = (port.file_field < decrement_skip_pkg::access_split);
  wire small_f   = (port.file_field <= decrement_skip_pkg::indexed_limit);
  wire [11:0] access_addr = low_part ?
    {decrement_skip_pkg::access_low_bank, port.file_field} :
    {decrement_skip_pkg::access_high_bank, port.file_field};
  wire [11:0] banked_addr  = {port.bank, port.file_field};
  wire [11:0] indexed_addr = port.index_base + {4'h0, port.file_field};

  // indexed literal offset mode
  assign port.indexed = in_access && port.extended_enable && small_f;
  // access bank or selected bank
  assign port.address = port.indexed ? indexed_addr :
                        (in_access ? access_addr : banked_addr);
endmodule

// *** verification/decrement_skip_execution_asserts.sv ***
// port assertions for the decrement-and-skip block
`timescale 1ns/10ps
module decrement_skip_execution_asserts (
  // clock and reset
  input wire logic        mclk,
  input wire logic        rst,
  // instruction in
  input wire logic [15:0] instr,
  input wire logic        instr_valid,
  input wire logic        next_two_word,
  // addressing context
  input wire logic [3:0]  bank_select_register,
  input wire logic        extended_enable,
  input wire logic [11:0] index_base,
  // data memory
  input wire logic [11:0] file_addr,
  input wire logic [7:0]  file_rdata,
  input wire logic [7:0]  file_wdata,
  input wire logic        file_we,
  // working register
  input wire logic [7:0]  work_wdata,
  input wire logic        work_we,
  // pipeline control
  input wire logic        busy,
  input wire logic        discard_next,
  input wire logic        nop_cycle,
  input wire logic        indexed_mode
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_dest_result: assert property (
    $rose(busy) |=> ($past(instr[9], 2) ? file_we && !work_we &&
    file_wdata == $past(file_rdata) - 8'h01 : work_we && !file_we &&
    work_wdata == $past(file_rdata) - 8'h01)) else $error("bad result");
  a_zero_skip: assert property (
    $rose(busy) && $past(instr[15:10]) == 6'h0b
    |=> discard_next == ($past(file_rdata) == 8'h01)) else $error("bad skip");
  a_nonzero_skip: assert property (
    $rose(busy) && $past(instr[15:10]) == 6'h13
    |=> discard_next == ($past(file_rdata) != 8'h01)) else $error("bad skip");
  a_one_nop: assert property (
    discard_next && !$past(next_two_word) |=> nop_cycle ##1 !nop_cycle)
    else $error("bad nop");
  a_two_nops: assert property (
    discard_next && $past(next_two_word) |=> nop_cycle[*2] ##1 !nop_cycle)
    else $error("bad nops");
  a_no_skip: assert property (
    $rose(busy) ##1 !discard_next |=> !nop_cycle) else $error("stray nop");
  a_bank_addr: assert property (
    $rose(busy) && $past(instr[8]) |-> !indexed_mode &&
    file_addr == {$past(bank_select_register), $past(instr[7:0])})
    else $error("bad bank address");
  a_access_addr: assert property (
    $rose(busy) && !$past(instr[8]) |-> indexed_mode == ($past(extended_enable)
    && $past(instr[7:0]) <= 8'h5f) && file_addr == (indexed_mode ?
    $past(index_base) + 12'($past(instr[7:0])) : {($past(instr[7:0]) < 8'h60
    ? 4'h0 : 4'hf), $past(instr[7:0])})) else $error("bad access address");
  a_other_opcode: assert property (
    !busy && instr_valid && instr[15:10] != 6'h0b && instr[15:10] != 6'h13
    |=> !busy) else $error("foreign opcode taken");
  c_skip: cover property (discard_next && file_we);
  c_two_nops: cover property (nop_cycle[*2]);
  c_work: cover property (work_we && !discard_next);
endmodule
bind decrement_skip_execution decrement_skip_execution_asserts i_chk (.*);

// *** verification/tb.sv ***
// randomised self-checking bench for the decrement-and-skip block
`timescale 1ns/10ps
`define chk(g, e) begin checks++; if ((g) !== (e)) begin miscompares++; \
  $display("Error at %0t: got %h expected %h", $time, g, e); end end
module tb;
  logic        mclk, rst, instr_valid, next_two_word, extended_enable;
  logic        file_we, work_we, busy, discard_next, nop_cycle, indexed_mode;
  logic [15:0] instr;
  logic [3:0]  bank_select_register;
  logic [11:0] index_base, file_addr;
  logic [7:0]  file_rdata, file_wdata, work_wdata;
  logic [31:0] rnd;
  int          checks, miscompares, seed;
  decrement_skip_execution i_dut (.*);
  always #50 mclk = ~mclk;
  function automatic logic [11:0] exp_addr(logic a, logic [7:0] f);
    if (a) return {bank_select_register, f};
    if (extended_enable && f <= 8'h5f) return index_base + {4'h0, f};
    return {(f < 8'h60 ? 4'h0 : 4'hf), f};
  endfunction
  function automatic logic exp_index(logic a, logic [7:0] f);
    return !a && extended_enable && f <= 8'h5f;
  endfunction
  task automatic run(logic [5:0] op, logic d, logic a, logic [7:0] f,
                     logic [7:0] r, logic tw);
    logic skip;
    int   n;
    int   nops;
    skip = (op == 6'h0b) == (r == 8'h01);
    instr = {op, d, a, f};
    instr_valid = 1'h1;
    next_two_word = tw;
    @(posedge mclk) #1;
    instr_valid = 1'h0;
    file_rdata = r;
    `chk(file_addr, exp_addr(a, f))
    `chk(indexed_mode, exp_index(a, f))
    @(posedge mclk) #1;
    `chk({file_we, work_we, discard_next}, {d, !d, skip})
    `chk(d ? file_wdata : work_wdata, r - 8'h01)
    n = 1;
    nops = 0;
    while (busy === 1'h1 && n < 9) begin
      @(posedge mclk) #1;
      n++;
      if (nop_cycle === 1'h1) nops++;
    end
    `chk(n, skip ? (tw ? 4 : 3) : 2)
    `chk(nops, skip ? (tw ? 2 : 1) : 0)
    $display("test done op %h f %h data %h", op, f, r);
  endtask
  task automatic results;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #100000;
    miscompares++;
    results();
  end
  initial begin
    {mclk, instr_valid, next_two_word, instr, file_rdata} = '0;
    {bank_select_register, checks, miscompares} = '0;
    {rst, extended_enable, index_base} = {2'h3, 12'hff0};
    seed = 32'h3b1c75fc;
    repeat (10) @(posedge mclk);
    #1 rst = 1'h0;
    @(posedge mclk) #1;
    instr = 16'h0610;
    instr_valid = 1'h1;
    @(posedge mclk) #1;
    `chk(busy, 1'h0)
    run(6'h0b, 1'h1, 1'h0, 8'h5f, 8'h01, 1'h0);
    run(6'h0b, 1'h0, 1'h0, 8'h60, 8'h01, 1'h1);
    run(6'h13, 1'h1, 1'h1, 8'h00, 8'h00, 1'h1);
    run(6'h13, 1'h0, 1'h0, 8'h10, 8'h01, 1'h0);
    repeat (40) begin
      rnd = $random(seed);
      bank_select_register = rnd[3:0];
      extended_enable = rnd[4];
      index_base = rnd[27:16];
      rnd = $random(seed);
      run(rnd[0] ? 6'h0b : 6'h13, rnd[1], rnd[2], rnd[15:8],
          rnd[3] ? 8'h01 : rnd[23:16], rnd[4]);
    end
    results();
  end
endmodule
